/* File: ssi_map.vh */
// Register offsets, field positions and constants of the serial shifter block.
`ifndef SSI_MAP_VH
`define SSI_MAP_VH
`define SSI_OFS_SHIFT      4'ha
`define SSI_OFS_AUX        4'hb
`define SSI_OFS_FLAGS      4'hd
`define SSI_OFS_ENABLES    4'he
`define SSI_MODE_HI        4
`define SSI_MODE_LO        2
`define SSI_MODE_OFF       3'h0
`define SSI_MODE_IN_T2     3'h1
`define SSI_MODE_IN_SYS    3'h2
`define SSI_MODE_IN_EXT    3'h3
`define SSI_MODE_OUT_FREE  3'h4
`define SSI_MODE_OUT_T2    3'h5
`define SSI_MODE_OUT_SYS   3'h6
`define SSI_MODE_OUT_EXT   3'h7
`define SSI_BIT_PA_SECOND  0
`define SSI_BIT_PA_FIRST   1
`define SSI_BIT_SHIFT      2
`define SSI_BIT_PB_SECOND  3
`define SSI_BIT_PB_FIRST   4
`define SSI_BIT_TIMER2     5
`define SSI_BIT_TIMER1     6
`define SSI_BIT_TOP        7
`define SSI_BITS_PER_BYTE  4'h8
`define SSI_LAST_BIT       4'h7
`define SSI_T2_EXTRA       9'h002
`define SSI_SYS_HALF       9'h001
`define SSI_RST_BYTE       8'h00
`define SSI_RST_FLAGS      7'h00
`define SSI_RST_DIV        9'h000
`define SSI_RST_CNT        4'h0
`endif

/* File: ssi_shifter.v */
// Serial shift register with interrupt flag and enable logic, plus its receive FIFO.
//////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Mode 000 stops shifting, pins follow peripheral control.
// - Mode 001 shifts in at second timer rate.
// - Shift-in starts on access; bits enter bit 0.
// - Timer-paced input captured two cycles after clock rise.
// - Mode 001 sets shift flag after eight pulses.
// - Mode 010 shifts in at system rate, stops.
// - Mode 011 external clock, flag every eight bits.
// - External modes: access clears flag, restarts counter.
// - Mode 100 recirculates out forever, no flag.
// - Out sends bit 7 first, rotates into bit 0.
// - Mode 101 access sends eight bits, eight pulses.
// - After eight out pulses stop, flag, hold pin.
// - Mode 110 shifts out at system clock rate.
// - Mode 111 external clock out, flag every eight.
// - Flag register readable; writing one clears flag.
// - Flag bit 7 is OR of enabled flags.
// - Enable write: bit 7 selects set or clear.
// - Enable read returns bit 7 as one.
// - Shift and timer flags set/cleared by events.
// - Port flags cleared by port output register access.
// - Independent second-line flags cleared only by writing.
// - Request output low when enabled flag set.
//////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none
`include "ssi_map.vh"

// Small synchronous FIFO; holds received bytes until the consumer takes them.
module ssi_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wp_r;
   reg [AW:0]      rp_r;
   wire            push;
   wire            pop;

   // Extra pointer bit tells full from empty when the indices meet.
   assign in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
   assign out_valid = (wp_r != rp_r);
   assign out_data  = mem[rp_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and storage update.
   always @(posedge clk) begin
      if (!rstn) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
            wp_r              <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule // ssi_fifo

//////////////////////////////////////////////////////////////////////////////////////
module ssi_shifter #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3
) (
   input  wire       clk,
   input  wire       rstn,
   input  wire       reg_cs,
   input  wire       reg_wr,
   input  wire [3:0] reg_sel,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output wire [7:0] auxiliary_control,
   input  wire [7:0] second_timer_low_latch,
   input  wire       first_timer_evt,
   input  wire       first_timer_clr,
   input  wire       second_timer_evt,
   input  wire       second_timer_clr,
   input  wire       port_a_first_line_evt,
   input  wire       port_a_second_line_evt,
   input  wire       port_b_first_line_evt,
   input  wire       port_b_second_line_evt,
   input  wire       port_a_output_reg_access,
   input  wire       port_b_output_reg_access,
   input  wire       port_a_second_indep,
   input  wire       port_b_second_indep,
   input  wire       pc_sclk_out,
   input  wire       pc_sclk_oe,
   input  wire       pc_sdata_out,
   input  wire       pc_sdata_oe,
   input  wire       sclk_in,
   output wire       sclk_out,
   output wire       sclk_oe,
   input  wire       sdata_in,
   output wire       sdata_out,
   output wire       sdata_oe,
   output wire       irq_n_out,
   output wire       irq_n_oe,
   output wire       rx_valid,
   input  wire       rx_ready,
   output wire [7:0] rx_data
);
   reg  [7:0] aux_r;
   reg  [7:0] shreg_r;
   reg  [6:0] flags_r;
   reg  [6:0] enables_r;
   reg  [3:0] cnt_r;
   reg  [8:0] div_r;
   reg        active_r;
   reg        sclk_r;
   reg        dout_r;
   reg  [1:0] pend_r;
   reg        push_r;
   reg  [7:0] push_data_r;
   reg  [2:0] sclk_sync_r;
   reg  [1:0] sdin_sync_r;
   reg  [6:0] flags_nxt;
   reg        shift_done;
   wire [2:0] mode;
   wire       mode_in;
   wire       mode_out;
   wire       mode_ext;
   wire       mode_int;
   wire       acc_sr;
   wire       wr_flags;
   wire       ext_rise;
   wire       ext_fall;
   wire       int_tick;
   wire       fifo_ready;
   wire [8:0] half;
   wire       any_irq;

   // Half period of the generated clock in system clocks.
   function [8:0] half_period;
      input [2:0] m;
      input [7:0] n;
      begin
         if (m == `SSI_MODE_IN_SYS || m == `SSI_MODE_OUT_SYS)
            half_period = `SSI_SYS_HALF;
         else
            half_period = {1'b0, n} + `SSI_T2_EXTRA;
      end
   endfunction
   // Register window access decode.
   function hit;
      input       cs;
      input [3:0] sel;
      input [3:0] ofs;
      begin
         hit = cs && (sel == ofs);
      end
   endfunction
   assign mode     = aux_r[`SSI_MODE_HI:`SSI_MODE_LO];
   assign mode_in  = (mode == `SSI_MODE_IN_T2) || (mode == `SSI_MODE_IN_SYS) ||
                     (mode == `SSI_MODE_IN_EXT);
   assign mode_out = mode[2];
   assign mode_ext = (mode == `SSI_MODE_IN_EXT) || (mode == `SSI_MODE_OUT_EXT);
   assign mode_int = (mode != `SSI_MODE_OFF) && !mode_ext;
   assign acc_sr   = hit(reg_cs, reg_sel, `SSI_OFS_SHIFT);
   assign wr_flags = hit(reg_cs, reg_sel, `SSI_OFS_FLAGS) && reg_wr;
   assign half     = half_period(mode, second_timer_low_latch);
   assign auxiliary_control = aux_r;

   // Outside pins pass two flops before use; the third stage only feeds edge detection.
   always @(posedge clk) begin
      if (!rstn) begin
         sclk_sync_r <= 3'h7;
         sdin_sync_r <= 2'h0;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
         sdin_sync_r <= {sdin_sync_r[0], sdata_in};
      end
   end
   assign ext_rise = sclk_sync_r[1] && !sclk_sync_r[2];
   assign ext_fall = !sclk_sync_r[1] && sclk_sync_r[2];

   // Generated clock stalls while a received byte cannot be stored.
   assign int_tick = active_r && mode_int && (div_r == `SSI_RST_DIV) &&
                     !(mode_in && !fifo_ready);

   // Shift engine: pulse generation, bit counting, data movement.
   always @(posedge clk) begin
      if (!rstn) begin
         active_r    <= 1'b0;
         sclk_r      <= 1'b1;
         div_r       <= `SSI_RST_DIV;
         cnt_r       <= `SSI_RST_CNT;
         shreg_r     <= `SSI_RST_BYTE;
         dout_r      <= 1'b0;
         pend_r      <= 2'h0;
         push_r      <= 1'b0;
         push_data_r <= `SSI_RST_BYTE;
         shift_done  <= 1'b0;
      end else begin
         push_r     <= 1'b0;
         shift_done <= 1'b0;
         pend_r     <= {pend_r[0], 1'b0};
         if (div_r != `SSI_RST_DIV && !(mode_in && !fifo_ready))
            div_r <= div_r - 1'b1;
         if (mode == `SSI_MODE_OFF) begin
            active_r <= 1'b0;
            sclk_r   <= 1'b1;
            cnt_r    <= `SSI_RST_CNT;
         end else if (int_tick) begin
            div_r  <= half - 1'b1;
            sclk_r <= !sclk_r;
            if (sclk_r && mode_out) begin
               dout_r  <= shreg_r[7];
               shreg_r <= {shreg_r[6:0], shreg_r[7]};
            end
            if (!sclk_r) begin
               pend_r[0] <= mode_in;
               if (cnt_r == `SSI_LAST_BIT) begin
                  cnt_r <= `SSI_RST_CNT;
                  if (mode != `SSI_MODE_OUT_FREE) begin
                     active_r   <= 1'b0;
                     shift_done <= !mode_in;
                  end
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
         end else if (mode_ext) begin
            if (ext_fall && mode_out) begin
               dout_r  <= shreg_r[7];
               shreg_r <= {shreg_r[6:0], shreg_r[7]};
            end
            if (ext_rise && (mode_out || fifo_ready)) begin
               if (mode_in)
                  shreg_r <= {shreg_r[6:0], sdin_sync_r[1]};
               if (cnt_r == `SSI_LAST_BIT) begin
                  cnt_r      <= `SSI_RST_CNT;
                  shift_done <= 1'b1;
                  push_r     <= mode_in;
                  push_data_r <= {shreg_r[6:0], sdin_sync_r[1]};
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
         end
         // Paced capture lags the rise by two cycles, so it reads the pin as it stood at the rise.
         if (pend_r[1]) begin
            shreg_r <= {shreg_r[6:0], sdin_sync_r[1]};
            if (!active_r) begin
               shift_done  <= 1'b1;
               push_r      <= 1'b1;
               push_data_r <= {shreg_r[6:0], sdin_sync_r[1]};
            end
         end
         if (mode == `SSI_MODE_OUT_FREE)
            active_r <= 1'b1;
         // Any shift register access outside mode 000 restarts the bit count; modes 001, 010, 101 and 110 then start a sequence of eight pulses.
         if (acc_sr && mode != `SSI_MODE_OFF) begin
            cnt_r    <= `SSI_RST_CNT;
            active_r <= mode_int;
            sclk_r   <= 1'b1;
            div_r    <= half - 1'b1;
            pend_r   <= 2'h0;
         end
         if (acc_sr && reg_wr)
            shreg_r <= reg_wdata;
      end
   end

   // Flag update: hardware set wins over every clear in the same cycle except the shift flag hold of modes 000 and 100.
   always @* begin
      flags_nxt = flags_r;
      if (wr_flags)
         flags_nxt = flags_nxt & ~reg_wdata[6:0];
      if (acc_sr)
         flags_nxt[`SSI_BIT_SHIFT] = 1'b0;
      if (first_timer_clr)
         flags_nxt[`SSI_BIT_TIMER1] = 1'b0;
      if (second_timer_clr)
         flags_nxt[`SSI_BIT_TIMER2] = 1'b0;
      if (port_a_output_reg_access) begin
         flags_nxt[`SSI_BIT_PA_FIRST] = 1'b0;
         if (!port_a_second_indep)
            flags_nxt[`SSI_BIT_PA_SECOND] = 1'b0;
      end
      if (port_b_output_reg_access) begin
         flags_nxt[`SSI_BIT_PB_FIRST] = 1'b0;
         if (!port_b_second_indep)
            flags_nxt[`SSI_BIT_PB_SECOND] = 1'b0;
      end
      flags_nxt = flags_nxt | {first_timer_evt, second_timer_evt, port_b_first_line_evt,
                               port_b_second_line_evt, shift_done, port_a_first_line_evt,
                               port_a_second_line_evt};
      if (mode == `SSI_MODE_OFF || mode == `SSI_MODE_OUT_FREE)
         flags_nxt[`SSI_BIT_SHIFT] = 1'b0;
   end

   // Control, flag and enable registers, plus registered read data.
   always @(posedge clk) begin
      if (!rstn) begin
         aux_r     <= `SSI_RST_BYTE;
         flags_r   <= `SSI_RST_FLAGS;
         enables_r <= `SSI_RST_FLAGS;
         reg_rdata <= `SSI_RST_BYTE;
      end else begin
         flags_r <= flags_nxt;
         if (hit(reg_cs, reg_sel, `SSI_OFS_AUX) && reg_wr)
            aux_r <= reg_wdata;
         if (hit(reg_cs, reg_sel, `SSI_OFS_ENABLES) && reg_wr) begin
            if (reg_wdata[`SSI_BIT_TOP])
               enables_r <= enables_r | reg_wdata[6:0];
            else
               enables_r <= enables_r & ~reg_wdata[6:0];
         end
         if (reg_cs && !reg_wr) begin
            case (reg_sel)
               `SSI_OFS_SHIFT:   reg_rdata <= shreg_r;
               `SSI_OFS_AUX:     reg_rdata <= aux_r;
               `SSI_OFS_FLAGS:   reg_rdata <= {any_irq, flags_r};
               `SSI_OFS_ENABLES: reg_rdata <= {1'b1, enables_r};
               default:          reg_rdata <= `SSI_RST_BYTE;
            endcase
         end
      end
   end

   // Request line is a wired-OR low; it is only ever pulled down, never driven high.
   assign any_irq   = |(flags_r & enables_r);
   assign irq_n_out = 1'b0;
   assign irq_n_oe  = any_irq;

   // Pin drive: mode 000 hands both pins back to the peripheral control settings.
   assign sclk_out  = (mode == `SSI_MODE_OFF) ? pc_sclk_out : sclk_r;
   assign sclk_oe   = (mode == `SSI_MODE_OFF) ? pc_sclk_oe  : mode_int;
   assign sdata_out = (mode == `SSI_MODE_OFF) ? pc_sdata_out : dout_r;
   assign sdata_oe  = (mode == `SSI_MODE_OFF) ? pc_sdata_oe  : mode_out;

   // Received bytes queue here; a full queue pauses the generated clock.
   ssi_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_rx_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (push_r),
      .in_ready  (fifo_ready),
      .in_data   (push_data_r),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );
endmodule // ssi_shifter
`default_nettype wire

/* File: ssi_shifter_chk.sv */
// Concurrent checks on the ports of the serial shifter block.
`timescale 1ns/100ps
`default_nettype none
module ssi_shifter_chk (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       reg_cs,
   input wire logic       reg_wr,
   input wire logic [3:0] reg_sel,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] auxiliary_control,
   input wire logic [7:0] second_timer_low_latch,
   input wire logic       pc_sclk_out,
   input wire logic       pc_sclk_oe,
   input wire logic       pc_sdata_out,
   input wire logic       pc_sdata_oe,
   input wire logic       sclk_out,
   input wire logic       sclk_oe,
   input wire logic       sdata_out,
   input wire logic       sdata_oe,
   input wire logic       irq_n_out,
   input wire logic       irq_n_oe,
   input wire logic       rx_valid
);
   wire logic [2:0] m;
   assign m = auxiliary_control[4:2];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   AST_IRQ_PIN: assert property (irq_n_out == 1'b0)
      else $error("request pin not pulled low");
   AST_IRQ_BIT7: assert property (reg_cs && !reg_wr && reg_sel == 4'hd
      |=> reg_rdata[7] == $past(irq_n_oe)) else $error("flag bit 7 differs from request");
   AST_IER_TOP: assert property (reg_cs && !reg_wr && reg_sel == 4'he |=> reg_rdata[7])
      else $error("enable bit 7 not one");
   AST_MODE0_PINS: assert property (m == 3'h0 |-> sclk_out == pc_sclk_out
      && sclk_oe == pc_sclk_oe && sdata_out == pc_sdata_out && sdata_oe == pc_sdata_oe)
      else $error("pins do not follow peripheral control");
   AST_FLAG_HELD: assert property (reg_cs && !reg_wr && reg_sel == 4'hd
      && (m == 3'h0 || m == 3'h4) |=> !reg_rdata[2]) else $error("shift flag not held");
   AST_DATA_DIR: assert property (m != 3'h0 |-> sdata_oe == m[2])
      else $error("data pin direction wrong");
   AST_CLK_DIR: assert property (m != 3'h0 |-> sclk_oe == (m[1:0] != 2'h3))
      else $error("clock pin direction wrong");
   // A full receive buffer may freeze the clock, so pace is judged only when it is empty.
   AST_SYS_PACE: assert property ((m == 3'h2 || m == 3'h6) && !rx_valid
      && $fell(sclk_out) |=> sclk_out) else $error("system paced low phase not one cycle");
   AST_T2_PACE: assert property ((m == 3'h1 || m[2:1] == 2'h2) && !rx_valid
      && second_timer_low_latch == 8'h00 && $fell(sclk_out) |-> !sclk_out [*2] ##1 sclk_out)
      else $error("timer paced low phase not two cycles");
   AST_OUT_HOLD: assert property ((m == 3'h5 || m == 3'h6) && $stable(m)
      && !$past(reg_cs) && $changed(sdata_out) |-> $fell(sclk_out))
      else $error("data pin moved off a falling clock");
endmodule // ssi_shifter_chk
bind ssi_shifter ssi_shifter_chk u_chk (
   .clk(clk), .rstn(rstn), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_sel(reg_sel),
   .reg_rdata(reg_rdata), .auxiliary_control(auxiliary_control),
   .second_timer_low_latch(second_timer_low_latch), .pc_sclk_out(pc_sclk_out),
   .pc_sclk_oe(pc_sclk_oe), .pc_sdata_out(pc_sdata_out), .pc_sdata_oe(pc_sdata_oe),
   .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .rx_valid(rx_valid));
`default_nettype wire

/* File: ssi_peer.sv */
// Behavioural model of the external serial device on the clock and data pins.
`timescale 1ns/100ps
`default_nettype none
module ssi_peer (
   input  wire logic       sclk_out,
   input  wire logic       sclk_oe,
   input  wire logic       sdata_out,
   input  wire logic       sdata_oe,
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   input  wire logic       ext_go,
   output logic            sclk_in,
   output logic            sdata_in,
   output logic [7:0]      rx_byte,
   output logic            done
);
   logic       ext_clk = 1'b1;
   logic       drv = 1'b0;
   logic [7:0] sh = 8'h00;
   int         n = 0;
   // Pin levels come from whichever side has its enable up; our clock idles high.
   assign sclk_in  = sclk_oe ? sclk_out : ext_clk;
   assign sdata_in = sdata_oe ? sdata_out : drv;
   // Loading arms a new byte and restarts the count of captured bits.
   always @(posedge load) begin
      sh = tx_byte;
      n = 0;
   end
   // Data moves only on a falling edge, so it is stable for the whole high phase.
   always @(negedge sclk_in) begin
      drv = sh[7];
      sh = {sh[6:0], ~sh[7]};
   end
   // Every rising edge samples the line; each eighth one completes a byte.
   always @(posedge sclk_in) begin
      rx_byte = {rx_byte[6:0], sdata_in};
      n = n + 1;
      if (n % 8 == 0) begin
         done = 1'b1;
         #5 done = 1'b0;
      end
   end
   // Eight external clock pulses at a 200 ns period, unrelated to the system clock.
   always @(posedge ext_go) begin
      repeat (8) begin
         #100 ext_clk = 1'b0;
         #100 ext_clk = 1'b1;
      end
   end
   initial begin
      rx_byte = 8'h00;
      done = 1'b0;
   end
endmodule // ssi_peer
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench of the serial shifter block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic       clk = 1'b0, rstn = 1'b0, cs = 1'b0, wr = 1'b0, load = 1'b0, ext_go = 1'b0;
   logic       rx_ready = 1'b0, rdy_on = 1'b0, rd_d = 1'b0;
   logic [3:0] sel = 4'h0, pc = 4'h0;
   logic [7:0] wd = 8'h00, latch = 8'h00, tx = 8'h00, r;
   logic [6:0] ev = 7'h00;
   logic [1:0] clr = 2'h0, acc = 2'h0, indep = 2'h0;
   logic [2:0] modes [5] = '{3'h1, 3'h5, 3'h6, 3'h3, 3'h7};
   wire  [7:0] rdata, aux, rx_data, peer_byte;
   wire        sclk_out, sclk_oe, sclk_in, sdata_out, sdata_oe, sdata_in;
   wire        irq_n_out, irq_n_oe, rx_valid, done;
   int         mismatches = 0, cmp_count = 0, cyc = 0;
   logic [7:0] rq [$], xq [$], pq [$];
   ssi_shifter u_dut (
      .clk(clk), .rstn(rstn), .reg_cs(cs), .reg_wr(wr), .reg_sel(sel), .reg_wdata(wd),
      .reg_rdata(rdata), .auxiliary_control(aux), .second_timer_low_latch(latch),
      .first_timer_evt(ev[6]), .first_timer_clr(clr[1]), .second_timer_evt(ev[5]),
      .second_timer_clr(clr[0]), .port_a_first_line_evt(ev[1]), .port_a_second_line_evt(ev[0]),
      .port_b_first_line_evt(ev[4]), .port_b_second_line_evt(ev[3]),
      .port_a_output_reg_access(acc[0]), .port_b_output_reg_access(acc[1]),
      .port_a_second_indep(indep[0]), .port_b_second_indep(indep[1]),
      .pc_sclk_out(pc[0]), .pc_sclk_oe(pc[1]), .pc_sdata_out(pc[2]), .pc_sdata_oe(pc[3]),
      .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_in(sdata_in),
      .sdata_out(sdata_out), .sdata_oe(sdata_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
   ssi_peer u_peer (
      .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
      .load(load), .tx_byte(tx), .ext_go(ext_go), .sclk_in(sclk_in), .sdata_in(sdata_in),
      .rx_byte(peer_byte), .done(done));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic results;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // One access per call; the strobe drops for a cycle so no edge sees it assigned twice.
   task automatic acc_reg(input logic w, input logic [3:0] s, input logic [7:0] d);
      @(posedge clk);
      cs <= 1'b1;
      wr <= w;
      sel <= s;
      wd <= d;
      @(posedge clk);
      cs <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] s, input logic [7:0] e);
      rq.push_back(e);
      acc_reg(1'b0, s, 8'h00);
   endtask
   task automatic pulse(input logic [6:0] e, input logic [1:0] c, input logic [1:0] a);
      @(posedge clk);
      {ev, clr, acc} <= {e, c, a};
      @(posedge clk);
      {ev, clr, acc} <= 11'h000;
   endtask
   // Arms the peer, notes the bytes each side must end up with, then writes the shift register, which starts the shift in the internally clocked modes.
   task automatic xfer(input logic [2:0] m);
      logic [7:0] t, d;
      t = $urandom;
      d = $urandom;
      @(posedge clk);
      tx <= t;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      pq.push_back(m[2] ? d : t);
      if (!m[2]) xq.push_back(t);
      if (m == 3'h4) pq.push_back(d);
      acc_reg(1'b1, 4'ha, d);
   endtask
   task automatic drain(input int lim);
      repeat (lim) if (pq.size() != 0 || (rdy_on && xq.size() != 0)) @(posedge clk);
   endtask
   task automatic fin(input string name);
      $display("test %s done", name);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Results are compared against the oldest note whenever they appear.
   always @(posedge clk) begin
      if (rd_d) cmp("reg_rdata", rq.pop_front(), rdata);
      if (rx_valid && rx_ready) cmp("rx_data", xq.pop_front(), rx_data);
      rd_d <= cs & ~wr;
      rx_ready <= rdy_on & 1'($urandom);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   always @(posedge done) if (pq.size() != 0) cmp("peer_byte", pq.pop_front(), peer_byte);
   initial begin
      void'($urandom(32'he0aae25e));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      pc <= $urandom | 4'h1; // Clock pin idles high in mode 000, so no false edge at a switch.
      r = $urandom;
      rd(4'hb, 8'h00);
      rd(4'he, 8'h80);
      acc_reg(1'b1, 4'h7, 8'hff);
      rd(4'h7, 8'h00);
      acc_reg(1'b1, 4'ha, r);
      rd(4'ha, r);
      rd(4'hd, 8'h00);
      acc_reg(1'b1, 4'he, {1'b1, r[6:0]});
      rd(4'he, {1'b1, r[6:0]});
      acc_reg(1'b1, 4'he, 8'h7f);
      rd(4'he, 8'h80);
      fin("registers");
      for (int i = 0; i < 7; i++) begin
         if (i != 2) begin
            pulse(7'(1 << i), 2'h0, 2'h0);
            rd(4'hd, 8'(1 << i));
            acc_reg(1'b1, 4'hd, 8'(1 << i));
         end
      end
      acc_reg(1'b1, 4'he, 8'hff);
      pulse(7'h7b, 2'h0, 2'h0);
      rd(4'hd, 8'hfb);
      indep <= 2'b01;
      pulse(7'h00, 2'h0, 2'h3);
      rd(4'hd, 8'he1);
      pulse(7'h00, 2'h3, 2'h0);
      rd(4'hd, 8'h81);
      acc_reg(1'b1, 4'hd, 8'h80);
      rd(4'hd, 8'h81);
      acc_reg(1'b1, 4'he, 8'h01);
      rd(4'hd, 8'h01);
      acc_reg(1'b1, 4'hd, 8'h01);
      rd(4'hd, 8'h00);
      indep <= 2'b00;
      fin("flags");
      // Nine bytes with the consumer stalled: eight fill the buffer, the ninth must wait.
      acc_reg(1'b1, 4'hb, 8'h08);
      repeat (9) begin
         xfer(3'h2);
         drain(200);
      end
      cmp("frozen", 8'h01, 8'(pq.size()));
      rdy_on <= 1'b1;
      drain(3000);
      fin("fifo fill");
      foreach (modes[i]) begin
         latch <= (modes[i] == 3'h5) ? 8'h00 : 8'($urandom_range(0, 3));
         acc_reg(1'b1, 4'hb, {3'h0, modes[i], 2'h0});
         xfer(modes[i]);
         rd(4'hd, 8'h00);
         if (modes[i][1:0] == 2'h3) pulse(7'h00, 2'h0, 2'h0);
         if (modes[i][1:0] == 2'h3) ext_go <= 1'b1;
         drain(3000);
         ext_go <= 1'b0;
         repeat (4) @(posedge clk);
         rd(4'hd, 8'h84);
         fin("shift mode");
      end
      // Load the byte while shifting is off, so the free run starts on fresh data.
      acc_reg(1'b1, 4'hb, 8'h00);
      xfer(3'h4);
      acc_reg(1'b1, 4'hb, 8'h10);
      drain(3000);
      rd(4'hd, 8'h00);
      acc_reg(1'b1, 4'hb, 8'h00);
      repeat (3) @(posedge clk);
      cmp("pending", 8'h00, 8'(pq.size() + xq.size() + rq.size()));
      fin("free run");
      results();
   end
endmodule // testbench
`default_nettype wire
